// file: rtl/mpl_pkg.sv
// Shared constants, modes, states and carriers of the Manchester programming link
package mpl_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS      = 32'h0000_000A;
    localparam int MSG_RX_TIMEOUT_NS  = 32'h0004_93E0;
    localparam int MSG_RX_CYC         = MSG_RX_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int EE_WRITE_DELAY_NS  = 32'h0131_2D00;
    localparam int EE_WRITE_CYC       = EE_WRITE_DELAY_NS / CLK_PERIOD_NS;
    localparam int PWM_HOLD_PERIODS   = 32'h0000_0002;
    localparam logic [7:0] SENT_HOLD_TICKS   = 8'h1E;
    localparam logic [7:0] SHARED_HOLD_TICKS = 8'h32;

    // ********************************************************
    // Widths and frame layout
    // ********************************************************
    localparam int TMR_W    = 24;
    localparam int BT_W     = 16;
    localparam int CNT_W    = 6;
    localparam int CS_W     = 4;
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 32;
    localparam int CRC_W    = 3;
    localparam int RD_BITS  = 1 + CS_W + ADDR_W + CRC_W;
    localparam int WR_BITS  = RD_BITS + DATA_W;
    localparam int ACK_BITS = CS_W + DATA_W + CRC_W;

    localparam logic [TMR_W-1:0]  TMR_STEP   = 24'h00_0001;
    localparam logic [TMR_W-1:0]  BT_LIMIT   = 24'h00_FFFF;
    localparam logic [CNT_W-1:0]  CNT_STEP   = 6'h01;
    localparam logic [CNT_W-1:0]  CNT_MAX    = 6'h3F;
    localparam logic [CRC_W-1:0]  CRC_PRESET = 3'h7;
    localparam logic [CRC_W-1:0]  CRC_GOOD   = 3'h0;
    localparam logic [CS_W-1:0]   CS_NONE    = 4'h0;
    localparam logic [CS_W-1:0]   CS_ALL     = 4'hF;
    localparam logic [CS_W-1:0]   CS_ONE     = 4'h1;
    localparam logic [ADDR_W-1:0] EE_ADDR_LAST = 7'h3F;
    localparam logic              RW_READ    = 1'h1;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        MODE_PWM         = 3'b000,
        MODE_SENT        = 3'b001,
        MODE_TRIG_SENT   = 3'b010,
        MODE_SHARED_SENT = 3'b011,
        MODE_ADDR_SENT   = 3'b100
    } mpl_mode_t;

    typedef enum logic [3:0] {
        ST_NORMAL     = 4'b0000,
        ST_GATE_RISE  = 4'b0001,
        ST_GATE_FALL  = 4'b0010,
        ST_FIRST_RISE = 4'b0011,
        ST_LINK_IDLE  = 4'b0100,
        ST_SYNC       = 4'b0101,
        ST_RX         = 4'b0110,
        ST_TURN       = 4'b0111,
        ST_TX         = 4'b1000,
        ST_EE_WAIT    = 4'b1001,
        ST_EE_MARK    = 4'b1010
    } mpl_state_t;

    typedef struct packed {
        mpl_mode_t   mode;
        logic [1:0]  die_addr;
        logic [15:0] pwm_period;
        logic [7:0]  sent_tick;
    } mpl_cfg_t;

    typedef struct packed {
        logic              rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mpl_cmd_t;

endpackage

// file: rtl/mpl_crc3.sv
// Three-bit CRC shift register, polynomial x^3+x+1, preset to all ones
`timescale 1ns/10ps
`default_nettype none

module mpl_crc3
    import mpl_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic             din,
    output logic [CRC_W-1:0]      crc
);

    logic fb;

    assign fb = crc[CRC_W-1] ^ din;

    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            crc <= CRC_PRESET;
        end else if (step) begin
            crc <= {crc[1], crc[0] ^ fb, fb};
        end
    end

endmodule

`default_nettype wire

// file: rtl/mpl_link.sv
// Manchester programming link: entry detection, frame receiver, answer transmitter
`timescale 1ns/10ps
`default_nettype none

// ********************************************************
// What this block does
// - PWM: no first rise in time, resume output
// - SENT: entry timeout restores normal output
// - Shared SENT: line released during gate time
// - Shared SENT: entry timeout resumes normal output
// - EEPROM write: wait, then falling completion edge
// - Manchester: one falls, zero rises mid-cell
// - Answer uses bit time of command frame
// - Two zero sync bits set bit time
// - Direction bit: zero writes, one reads
// - Four-bit chip select, all or none broadcast
// - Seven-bit register address follows chip select
// - Writes carry 32 data bits, reads none
// - Every frame ends in three CRC bits
// - Answer chip select is one-hot die address
// - Answer data field is 32 bits
// - Data bit 0 is least significant
// - CRC x^3+x+1, preset 111, sync excluded
// ********************************************************

module mpl_link
    import mpl_pkg::*;
#(
    parameter int MSG_RX_CYCLES = MSG_RX_CYC,
    parameter int EE_CYCLES     = EE_WRITE_CYC
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              line_in,
    input  wire logic              norm_low,
    input  wire logic              leave_link,
    input  wire mpl_cfg_t          cfg,
    input  wire logic [DATA_W-1:0] rd_data,
    output logic                   line_out,
    output logic                   line_oe_n,
    output logic                   link_active,
    output logic                   cmd_valid,
    output mpl_cmd_t               cmd,
    output logic                   entry_abort,
    output logic                   frame_error,
    output logic                   ee_busy
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic                line_s1;
    logic                line_s2;
    logic                line_d;
    logic                rise;
    logic                fall;
    mpl_state_t          st;
    mpl_state_t          next_st;
    logic                tmr_clr;
    logic [TMR_W-1:0]    tmr;
    logic [TMR_W-1:0]    ent_tmr;
    logic                entering;
    logic                timeout;
    logic [2:0]          drv_hist;
    logic [TMR_W-1:0]    aux_cnt;
    logic [TMR_W-1:0]    hold_req;
    logic                aux_hit;
    logic [BT_W-1:0]     bt;
    logic [TMR_W-1:0]    bt_w;
    logic [TMR_W-1:0]    half_w;
    logic [TMR_W-1:0]    tq_w;
    logic [TMR_W-1:0]    oh_w;
    logic [WR_BITS-1:0]  rx_sr;
    logic [CNT_W-1:0]    rx_n;
    logic [CRC_W-1:0]    rx_crc;
    logic                rx_tick;
    logic                rx_end;
    logic                rx_done;
    logic                is_rd;
    logic                is_wr;
    logic [CS_W-1:0]     rx_cs;
    logic [ADDR_W-1:0]   rx_addr;
    logic                good;
    logic [ACK_BITS-1:0] tx_sr;
    logic [CNT_W-1:0]    tx_n;
    logic                tx_bit;
    logic                tx_start;
    logic                tx_b;
    logic                tx_half;
    logic [CRC_W-1:0]    tx_crc;

    // ********************************************************
    // Pin synchroniser and edges
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            line_s1 <= 1'b1;
            line_s2 <= 1'b1;
            line_d  <= 1'b1;
        end else begin
            line_s1 <= line_in;
            line_s2 <= line_s1;
            line_d  <= line_s2;
        end
    end

    assign rise = line_s2 & ~line_d;
    assign fall = ~line_s2 & line_d;

    // ********************************************************
    // Auxiliary pulse detection
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_req <= '0;
        end else begin
            unique case (cfg.mode)
                MODE_PWM:
                    hold_req <= TMR_W'(cfg.pwm_period) * TMR_W'(PWM_HOLD_PERIODS);
                MODE_SENT, MODE_TRIG_SENT:
                    hold_req <= TMR_W'(cfg.sent_tick) * TMR_W'(SENT_HOLD_TICKS);
                MODE_SHARED_SENT, MODE_ADDR_SENT:
                    hold_req <= TMR_W'(cfg.sent_tick) * TMR_W'(SHARED_HOLD_TICKS);
                default:
                    hold_req <= TMR_W'(cfg.pwm_period) * TMR_W'(PWM_HOLD_PERIODS);
            endcase
        end
    end

    assign aux_hit = ~line_s2 & (aux_cnt >= hold_req) & (aux_cnt != '0);

    // Only low time not caused by our own driver counts
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drv_hist <= '0;
            aux_cnt  <= '0;
        end else begin
            drv_hist <= {drv_hist[1:0], ~line_oe_n};
            if (st != ST_NORMAL || line_s2 || drv_hist != '0) begin
                aux_cnt <= '0;
            end else if (!aux_hit) begin
                aux_cnt <= aux_cnt + TMR_STEP;
            end
        end
    end

    // ********************************************************
    // Bit timing and frame decode
    // ********************************************************
    assign bt_w    = TMR_W'(bt);
    assign half_w  = bt_w >> 1;
    assign tq_w    = bt_w - (bt_w >> 2);
    assign oh_w    = bt_w + half_w;
    assign timeout = entering & (ent_tmr >= TMR_W'(MSG_RX_CYCLES))
                   & (st == ST_GATE_RISE || st == ST_GATE_FALL || st == ST_FIRST_RISE);
    assign rx_end  = (st == ST_RX) & (tmr >= oh_w);
    assign rx_tick = (st == ST_RX) & ~rx_end & (tmr >= tq_w) & (rise | fall);
    assign rx_done = rx_end;

    assign is_rd   = (rx_n == CNT_W'(RD_BITS)) & (rx_sr[RD_BITS-1] == RW_READ);
    assign is_wr   = (rx_n == CNT_W'(WR_BITS)) & (rx_sr[WR_BITS-1] != RW_READ);
    assign rx_cs   = is_rd ? rx_sr[RD_BITS-2 -: CS_W] : rx_sr[WR_BITS-2 -: CS_W];
    assign rx_addr = is_rd ? rx_sr[RD_BITS-2-CS_W -: ADDR_W]
                           : rx_sr[WR_BITS-2-CS_W -: ADDR_W];
    assign good    = (is_rd | is_wr) & (rx_crc == CRC_GOOD)
                   & (rx_cs == CS_NONE || rx_cs == CS_ALL || rx_cs[cfg.die_addr]);

    // ********************************************************
    // State machine
    // ********************************************************
    always_comb begin
        next_st = st;
        tmr_clr = 1'b0;
        unique case (st)
            ST_NORMAL: begin
                if (aux_hit) begin
                    next_st = ST_GATE_RISE;
                end
            end
            ST_GATE_RISE: begin
                if (timeout) begin
                    next_st = ST_NORMAL;
                end else if (rise) begin
                    next_st = ST_GATE_FALL;
                end
            end
            ST_GATE_FALL: begin
                if (timeout) begin
                    next_st = ST_NORMAL;
                end else if (fall) begin
                    next_st = ST_FIRST_RISE;
                end
            end
            ST_FIRST_RISE: begin
                if (timeout) begin
                    next_st = ST_NORMAL;
                end else if (rise) begin
                    next_st = ST_SYNC;
                end
            end
            ST_LINK_IDLE: begin
                if (leave_link) begin
                    next_st = ST_NORMAL;
                end else if (fall) begin
                    next_st = ST_FIRST_RISE;
                end
            end
            ST_SYNC: begin
                if (rise) begin
                    next_st = ST_RX;
                end else if (tmr == BT_LIMIT) begin
                    next_st = ST_LINK_IDLE;
                end
            end
            ST_RX: begin
                if (rx_end) begin
                    if (!good) begin
                        next_st = ST_LINK_IDLE;
                    end else if (is_rd) begin
                        next_st = ST_TURN;
                    end else if (rx_addr <= EE_ADDR_LAST) begin
                        next_st = ST_EE_WAIT;
                    end else begin
                        next_st = ST_LINK_IDLE;
                    end
                end else if (rx_tick) begin
                    tmr_clr = 1'b1;
                end
            end
            ST_TURN: begin
                if (tmr == bt_w - TMR_STEP) begin
                    next_st = ST_TX;
                end
            end
            ST_TX: begin
                if (tmr == bt_w - TMR_STEP) begin
                    if (tx_n == CNT_W'(ACK_BITS - 1)) begin
                        next_st = ST_LINK_IDLE;
                    end else begin
                        tmr_clr = 1'b1;
                    end
                end
            end
            ST_EE_WAIT: begin
                if (tmr == TMR_W'(EE_CYCLES - 1)) begin
                    next_st = ST_EE_MARK;
                end
            end
            ST_EE_MARK: begin
                if (tmr == bt_w - TMR_STEP) begin
                    next_st = ST_LINK_IDLE;
                end
            end
            default: begin
                next_st = ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st  <= ST_NORMAL;
            tmr <= '0;
        end else begin
            st  <= next_st;
            tmr <= (tmr_clr || next_st != st) ? '0 : tmr + TMR_STEP;
        end
    end

    // Entry window timer runs from the end of the hold period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            entering <= 1'b0;
            ent_tmr  <= '0;
        end else if (st == ST_NORMAL && next_st == ST_GATE_RISE) begin
            entering <= 1'b1;
            ent_tmr  <= '0;
        end else if (timeout || next_st == ST_SYNC) begin
            entering <= 1'b0;
        end else begin
            ent_tmr  <= ent_tmr + TMR_STEP;
        end
    end

    // ********************************************************
    // Receiver
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bt    <= '1;
            rx_sr <= '0;
            rx_n  <= '0;
        end else if (st == ST_SYNC && rise) begin
            bt    <= BT_W'(tmr + TMR_STEP);
            rx_n  <= '0;
        end else if (rx_tick) begin
            rx_sr <= {rx_sr[WR_BITS-2:0], fall};
            if (rx_n != CNT_MAX) begin
                rx_n <= rx_n + CNT_STEP;
            end
        end
    end

    mpl_crc3 u_rx_crc (
        .clock (clock),
        .rst_n (rst_n),
        .clear (st == ST_SYNC),
        .step  (rx_tick),
        .din   (fall),
        .crc   (rx_crc)
    );

    // ********************************************************
    // Answer transmitter
    // ********************************************************
    assign tx_start = (st == ST_TURN && next_st == ST_TX)
                    | (st == ST_TX && next_st == ST_TX && tmr == bt_w - TMR_STEP);
    assign tx_b     = (st == ST_TURN) ? tx_sr[ACK_BITS-1]
                    : (tx_n == CNT_W'(CS_W + DATA_W - 1)) ? tx_crc[CRC_W-1]
                    : tx_sr[ACK_BITS-2];
    assign tx_half  = (st == ST_TX) & (next_st == ST_TX) & (tmr == half_w - TMR_STEP);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_sr  <= '0;
            tx_n   <= '0;
            tx_bit <= 1'b0;
        end else if (st == ST_TURN && tmr == '0) begin
            tx_sr <= {CS_ONE << cfg.die_addr, rd_data, CRC_GOOD};
        end else if (tx_start) begin
            tx_bit <= tx_b;
            if (st == ST_TURN) begin
                tx_n <= '0;
            end else begin
                tx_n <= tx_n + CNT_STEP;
                if (tx_n == CNT_W'(CS_W + DATA_W - 1)) begin
                    tx_sr <= {tx_crc, tx_sr[ACK_BITS-2 -: ACK_BITS-CRC_W-1], 1'b0};
                end else begin
                    tx_sr <= {tx_sr[ACK_BITS-2:0], 1'b0};
                end
            end
        end
    end

    mpl_crc3 u_tx_crc (
        .clock (clock),
        .rst_n (rst_n),
        .clear (st == ST_TURN && tmr == '0),
        .step  (tx_start && (st == ST_TURN || tx_n < CNT_W'(CS_W + DATA_W - 1))),
        .din   (tx_b),
        .crc   (tx_crc)
    );

    // ********************************************************
    // Line driver and status outputs
    // ********************************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            line_out  <= 1'b0;
            line_oe_n <= 1'b1;
        end else begin
            line_out <= 1'b0;
            if (next_st == ST_NORMAL) begin
                line_oe_n <= ~norm_low;
            end else if (tx_start) begin
                line_oe_n <= tx_b;
            end else if (tx_half) begin
                line_oe_n <= ~tx_bit;
            end else if (next_st == ST_EE_MARK) begin
                line_oe_n <= 1'b0;
            end else if (next_st != ST_TX) begin
                line_oe_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            link_active <= 1'b0;
            entry_abort <= 1'b0;
            cmd_valid   <= 1'b0;
            frame_error <= 1'b0;
            ee_busy     <= 1'b0;
            cmd         <= '0;
        end else begin
            entry_abort <= timeout;
            cmd_valid   <= rx_done & good;
            frame_error <= rx_done & ~good;
            ee_busy     <= (next_st == ST_EE_WAIT);
            if (next_st == ST_NORMAL) begin
                link_active <= 1'b0;
            end else if (next_st == ST_SYNC) begin
                link_active <= 1'b1;
            end
            if (rx_done && good) begin
                cmd.rw   <= is_rd;
                cmd.addr <= rx_addr;
                cmd.data <= is_rd ? '0 : rx_sr[CRC_W +: DATA_W];
            end
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_abort_time;
        @(posedge clock) disable iff (!rst_n)
        entry_abort |-> $past(ent_tmr) >= TMR_W'(MSG_RX_CYCLES) && st == ST_NORMAL;
    endproperty
    a_abort_time: assert property (p_abort_time) else $error("Entry aborted early");

    property p_abort_restore;
        @(posedge clock) disable iff (!rst_n)
        entry_abort |-> line_oe_n == !$past(norm_low) && !link_active;
    endproperty
    a_abort_restore: assert property (p_abort_restore) else $error("Output not restored");

    property p_abort_from_entry;
        @(posedge clock) disable iff (!rst_n)
        entry_abort |-> $past(entering) && !$past(link_active) && $past(line_oe_n);
    endproperty
    a_abort_from_entry: assert property (p_abort_from_entry) else $error("Abort outside entry");

    property p_ee_mark;
        @(posedge clock) disable iff (!rst_n)
        (st == ST_EE_WAIT && tmr == TMR_W'(EE_CYCLES - 1)) |=> st == ST_EE_MARK && !line_oe_n;
    endproperty
    a_ee_mark: assert property (p_ee_mark) else $error("No completion edge");

    property p_tx_edges;
        @(posedge clock) disable iff (!rst_n)
        (st == ST_TX && $past(st) == ST_TX && line_oe_n != $past(line_oe_n))
        |-> ($past(tmr) == half_w - TMR_STEP || $past(tmr) == bt_w - TMR_STEP);
    endproperty
    a_tx_edges: assert property (p_tx_edges) else $error("Answer edge off bit time");

    property p_ack_cs;
        @(posedge clock) disable iff (!rst_n)
        (st == ST_TURN && next_st == ST_TX) |-> tx_sr[ACK_BITS-1 -: CS_W] == (CS_ONE << cfg.die_addr);
    endproperty
    a_ack_cs: assert property (p_ack_cs) else $error("Answer select not one-hot");

    property p_ack_data;
        @(posedge clock) disable iff (!rst_n)
        (st == ST_TURN && tmr == '0) |=> tx_sr[ACK_BITS-1-CS_W -: DATA_W] == $past(rd_data);
    endproperty
    a_ack_data: assert property (p_ack_data) else $error("Answer data wrong");

    property p_discard;
        @(posedge clock) disable iff (!rst_n)
        (rx_done && !good) |=> !cmd_valid && frame_error && st == ST_LINK_IDLE;
    endproperty
    a_discard: assert property (p_discard) else $error("Bad frame not discarded");

    property p_release;
        @(posedge clock) disable iff (!rst_n)
        (st inside {ST_SYNC, ST_RX} && $past(st) inside {ST_SYNC, ST_RX}) |-> line_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("Line driven during receive");

endmodule

`default_nettype wire

// file: verification/mpl_host.sv
// Programming controller model on the shared pin
`timescale 1ns/10ps
`default_nettype none
module mpl_host (
    input  wire logic clock,
    output logic      host_low
);
    initial host_low = 1'b0;
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic enter(input int hold, input int gate);
        host_low = 1'b1;
        wait_cyc(hold);
        host_low = 1'b0;
        if (gate > 0) begin
            wait_cyc(gate);
            host_low = 1'b1;
            wait_cyc(gate);
        end
    endtask
    task automatic frame(input logic [63:0] v, input int n, input int bt);
        for (int i = n + 1; i >= 0; i--) begin
            host_low = (i < n) ? !v[i] : 1'b1;
            wait_cyc(bt / 2);
            host_low = !host_low;
            wait_cyc(bt / 2);
        end
        host_low = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/mpl_link_tb_top.sv
// Testbench of the Manchester programming link
`timescale 1ns/10ps
`default_nettype none
module mpl_link_tb_top;
    import mpl_pkg::*;
    localparam int BT = 20;
    logic clock = 1'b0, rst_n, norm_low, leave_link;
    logic host_low, line_out, line_oe_n, link_active, cmd_valid, entry_abort, frame_error, ee_busy, pin;
    mpl_cfg_t          cfg;
    logic [DATA_W-1:0] rd_data;
    mpl_cmd_t          cmd;
    int                fails   = 0, checks = 0, cyc = 0;
    assign pin = !(host_low || (!line_oe_n && !line_out));
    always #5 clock = !clock;
    mpl_host HOST (.clock(clock), .host_low(host_low));
    mpl_link #(.MSG_RX_CYCLES(200), .EE_CYCLES(50)) DUT (.clock(clock), .rst_n(rst_n), .line_in(pin),
        .norm_low(norm_low), .leave_link(leave_link), .cfg(cfg), .rd_data(rd_data), .line_out(line_out),
        .line_oe_n(line_oe_n), .link_active(link_active), .cmd_valid(cmd_valid), .cmd(cmd),
        .entry_abort(entry_abort), .frame_error(frame_error), .ee_busy(ee_busy));
    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [2:0] crc3(input logic [63:0] v, input int n);
        logic [2:0] c;
        c = CRC_PRESET;
        for (int i = n - 1; i >= 0; i--)
            c = {c[1], c[0] ^ c[2] ^ v[i], c[2] ^ v[i]};
        return c;
    endfunction
    function automatic logic sel(input int k);
        return (k == 0) ? cmd_valid : (k == 1) ? frame_error : (k == 2) ? entry_abort : !line_oe_n;
    endfunction
    task automatic wait_for(input int k, input int max, input logic exp);
        int n;
        n = 0;
        while (sel(k) !== 1'b1 && n < max) begin
            @(negedge clock);
            n++;
        end
        chk(sel(k), exp);
    endtask
    task automatic send(input logic rw, input logic [3:0] cs, input logic [6:0] a, input logic [31:0] d,
                        input logic bad);
        logic [63:0] v;
        int          n;
        v = rw ? 64'({rw, cs, a}) : 64'({rw, cs, a, d});
        n = rw ? 12 : 44;
        v = (v << 3) | 64'(crc3(v, n) ^ {2'h0, bad});
        HOST.frame(v, n + 3, BT);
    endtask
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_read(input logic [3:0] cs);
        logic [38:0] a, b, e;
        send(1'b1, cs, 7'h12, 32'h0, 1'b0);
        wait_for(0, 3 * BT, 1'b1);
        chk({cmd.rw, cmd.addr}, {1'b1, 7'h12});
        wait_for(3, 3 * BT, 1'b1);
        e = {4'h1 << cfg.die_addr, rd_data, 3'h0};
        e[2:0] = crc3(64'(e[38:3]), 36);
        for (int i = 38; i >= 0; i--) begin
            HOST.wait_cyc(BT / 4);
            a[i] = line_oe_n;
            HOST.wait_cyc(BT / 2);
            b[i] = !line_oe_n;
            HOST.wait_cyc(BT / 4);
        end
        chk(a, e);
        chk(b, e);
        HOST.wait_cyc(BT);
    endtask
    task automatic t_write(input logic [6:0] a);
        logic ee;
        ee = (a <= EE_ADDR_LAST);
        send(1'b0, 4'hF, a, {a, 25'h1_A5A5}, 1'b0);
        wait_for(0, 3 * BT, 1'b1);
        chk(cmd, {1'b0, a, a, 25'h1_A5A5});
        HOST.wait_cyc(2);
        chk(ee_busy, ee);
        wait_for(3, 60, ee);
        chk(line_out, 1'b0);
        HOST.wait_cyc(BT + 2);
        chk(line_oe_n, 1'b1);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim;
        end
    end
    initial begin
        rst_n      = 1'b0;
        norm_low   = 1'b0;
        leave_link = 1'b0;
        cfg        = '{MODE_PWM, 2'h1, 16'h0008, 8'h01};
        rd_data    = 32'h0ABC_0123;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        HOST.wait_cyc(4);
        norm_low = 1'b1;
        HOST.wait_cyc(2);
        chk(line_oe_n, 1'b0);
        norm_low = 1'b0;
        HOST.wait_cyc(4);
        for (int m = 0; m < 5; m++) begin
            cfg.mode = mpl_mode_t'(m);
            HOST.enter(m == 0 ? 26 : m < 3 ? 40 : 60, 0);
            wait_for(2, 260, 1'b1);
            chk(link_active, 1'b0);
            HOST.wait_cyc(4);
        end
        cfg.mode = MODE_PWM;
        HOST.enter(26, BT);
        t_read(4'h2);
        chk(link_active, 1'b1);
        cfg.die_addr = 2'h0;
        rd_data      = 32'h0123_0ABC;
        t_read(4'hF);
        cfg.die_addr = 2'h1;
        for (int i = 0; i < 2; i++) begin
            send(1'b1, i ? 4'h4 : 4'h2, 7'h12, 32'h0, !i);
            wait_for(1, 3 * BT, 1'b1);
            wait_for(3, 3 * BT, 1'b0);
        end
        t_write(7'h12);
        t_write(7'h40);
        leave_link = 1'b1;
        HOST.wait_cyc(3);
        chk(link_active, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
